// [ldcc_config_bank.sv]
// configuration register bank of the video link deserializer control path
// assumes an internal register port driven by the serial-bus target logic
// on sys_clk_in; sync and data-enable pins arrive asynchronously
//
// Overview of operation
// - bit 6 of general config enables back-channel crc generator, reset on
// - bit 5 of general config: 1 pulls undriven inputs down, 0 up
// - filter bit set rejects de, hsync, vsync pulses under two clocks
// - hsync filter is two clocks single-lane, four clocks dual-lane
// - bit 3 forwards address-matched serial-bus transactions to serializer
// - bit 2 auto-acknowledges serial-bus writes regardless of lock state
// - protected-serializer pairing always gates rgb with data enable
// - plain serializer passes rgb ungated unless gating bit is one
// - watchdog timeout is bits 7..1, 2 ms units, reset 0x7f
// - enabled watchdog terminates control transactions exceeding the timeout
// - watchdog register bit 0 disables watchdog when one, reset zero
// - bit 7 of bus control one passes every transaction through
// - bus control one bits 6..4 set sda hold, 50 ns units
// - bus control one bits 3..0 set glitch depth, 5 ns units
// - back channel turns off only if both pass-through bits are zero
`timescale 1ns/1ns
module ldcc_config_bank
   import ldcc_pkg::*;
#(
   parameter int unsigned WD_STEP_CYCLES = LDCC_WD_STEP_CYCLES
)
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic [7:0]            reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic      [7:0]            reg_rdata_out,
   output logic                       reg_rvalid_out,
   input  wire logic                  data_enable_in,
   input  wire logic                  horizontal_sync_in,
   input  wire logic                  vertical_sync_in,
   input  wire logic                  dual_lane_in,
   input  wire logic                  protected_pair_in,
   input  wire logic [LDCC_RGB_W-1:0] rgb_in,
   input  wire logic                  backchan_on_in,
   input  wire logic                  ctrl_txn_busy_in,
   output logic                       data_enable_out,
   output logic                       horizontal_sync_out,
   output logic                       vertical_sync_out,
   output logic      [LDCC_RGB_W-1:0] rgb_out,
   output logic                       backchan_crc_gen_on_out,
   output logic                       undriven_pull_down_sel_out,
   output logic                       pass_decode_out,
   output logic                       pass_all_out,
   output logic                       auto_ack_out,
   output logic                       backchan_active_out,
   output logic      [2:0]            sda_hold_out,
   output logic      [3:0]            glitch_depth_out,
   output logic                       ctrl_txn_abort_out
);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] gen_cfg1_reg;
   logic [7:0] watchdog_reg;
   logic [7:0] sbus_ctrl1_reg;

   logic [3:0] hit;

   // one offset decode shared by the write and read paths
   function automatic logic [3:0] reg_hit(input logic [7:0] addr);
      logic [3:0] sel;
      sel    = 4'h0;
      sel[0] = (addr == LDCC_OFS_GEN_CFG1);
      sel[1] = (addr == LDCC_OFS_WATCHDOG);
      sel[2] = (addr == LDCC_OFS_SBUS_CTRL1);
      sel[3] = (addr == LDCC_OFS_SBUS_CTRL2);
      return sel;
   endfunction

   assign hit = reg_hit(reg_addr_in);

   // general config one; bit 0 stays at its reset value
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         gen_cfg1_reg <= LDCC_RST_GEN_CFG1;
      end
      else if (reg_wr_in && hit[0])
      begin
         gen_cfg1_reg <= (reg_wdata_in & LDCC_GEN_CFG1_WMASK) |
            (LDCC_RST_GEN_CFG1 & ~LDCC_GEN_CFG1_WMASK);
      end
   end

   // watchdog control
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         watchdog_reg <= LDCC_RST_WATCHDOG;
      end
      else if (reg_wr_in && hit[1])
      begin
         watchdog_reg <= reg_wdata_in;
      end
   end

   // bus control one; 0x06 fields live elsewhere, so writes there drop
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         sbus_ctrl1_reg <= LDCC_RST_SBUS_CTRL1;
      end
      else if (reg_wr_in && hit[2])
      begin
         sbus_ctrl1_reg <= reg_wdata_in;
      end
   end

   // read data; reading never alters a field
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end
      else
      begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in)
         begin
            if (hit[0])
            begin
               reg_rdata_out <= gen_cfg1_reg;
            end
            else if (hit[1])
            begin
               reg_rdata_out <= watchdog_reg;
            end
            else if (hit[2])
            begin
               reg_rdata_out <= sbus_ctrl1_reg;
            end
            else if (hit[3])
            begin
               reg_rdata_out <= LDCC_RST_SBUS_CTRL2;
            end
            else
            begin
               reg_rdata_out <= 8'h00;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // static controls, registered so outputs come straight from flops
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         backchan_crc_gen_on_out    <= LDCC_RST_GEN_CFG1[LDCC_B_CRC_GEN];
         undriven_pull_down_sel_out <= LDCC_RST_GEN_CFG1[LDCC_B_PULL_DOWN];
         pass_decode_out            <= LDCC_RST_GEN_CFG1[LDCC_B_PASS_DEC];
         pass_all_out               <= LDCC_RST_SBUS_CTRL1[LDCC_B_PASS_ALL];
         auto_ack_out               <= LDCC_RST_GEN_CFG1[LDCC_B_AUTO_ACK];
         backchan_active_out        <= 1'b1;
         sda_hold_out               <=
            LDCC_RST_SBUS_CTRL1[LDCC_B_HOLD_HI:LDCC_B_HOLD_LO];
         glitch_depth_out           <=
            LDCC_RST_SBUS_CTRL1[LDCC_B_DEPTH_HI:LDCC_B_DEPTH_LO];
      end
      else
      begin
         backchan_crc_gen_on_out    <= gen_cfg1_reg[LDCC_B_CRC_GEN];
         undriven_pull_down_sel_out <= gen_cfg1_reg[LDCC_B_PULL_DOWN];
         pass_decode_out            <= gen_cfg1_reg[LDCC_B_PASS_DEC];
         pass_all_out               <= sbus_ctrl1_reg[LDCC_B_PASS_ALL];
         auto_ack_out               <= gen_cfg1_reg[LDCC_B_AUTO_ACK];
         backchan_active_out        <= backchan_on_in |
            gen_cfg1_reg[LDCC_B_PASS_DEC] |
            sbus_ctrl1_reg[LDCC_B_PASS_ALL];
         sda_hold_out     <= sbus_ctrl1_reg[LDCC_B_HOLD_HI:LDCC_B_HOLD_LO];
         glitch_depth_out <= sbus_ctrl1_reg[LDCC_B_DEPTH_HI:LDCC_B_DEPTH_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sync pin filtering: 0 data enable, 1 hsync, 2 vsync
   logic [2:0] pin_raw;
   logic [2:0] pin_filt;

   assign pin_raw = {vertical_sync_in, horizontal_sync_in, data_enable_in};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_filt
         logic [LDCC_SYNC_STAGES-1:0] sync_reg;
         logic [1:0]                  run_reg;
         logic                        out_reg;
         logic [1:0]                  need;

         // only hsync stretches to four clocks on a dual-lane link
         assign need = (gi == 1 && dual_lane_in) ?
            2'(LDCC_FILT_DUAL - 1) : 2'(LDCC_FILT_SINGLE - 1);

         always_ff @(posedge sys_clk_in)
         begin
            if (sys_rst_in)
            begin
               sync_reg <= '0;
            end
            else
            begin
               sync_reg <= {sync_reg[LDCC_SYNC_STAGES-2:0], pin_raw[gi]};
            end
         end

         // level counts only once stages two and three agree
         always_ff @(posedge sys_clk_in)
         begin
            if (sys_rst_in)
            begin
               run_reg <= 2'd0;
               out_reg <= 1'b0;
            end
            else if (sync_reg[1] != sync_reg[2])
            begin
               run_reg <= 2'd0;
            end
            else if (!gen_cfg1_reg[LDCC_B_FILTER])
            begin
               run_reg <= 2'd0;
               out_reg <= sync_reg[2];
            end
            else if (sync_reg[2] == out_reg)
            begin
               run_reg <= 2'd0;
            end
            else if (run_reg >= need - 2'd1)
            begin
               run_reg <= 2'd0;
               out_reg <= sync_reg[2];
            end
            else
            begin
               run_reg <= run_reg + 2'd1;
            end
         end

         assign pin_filt[gi] = out_reg;
      end
   endgenerate

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         data_enable_out     <= 1'b0;
         horizontal_sync_out <= 1'b0;
         vertical_sync_out   <= 1'b0;
      end
      else
      begin
         data_enable_out     <= pin_filt[0];
         horizontal_sync_out <= pin_filt[1];
         vertical_sync_out   <= pin_filt[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rgb gating; pixel path is not delayed to match the filter latency
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         rgb_out <= '0;
      end
      else if ((protected_pair_in | gen_cfg1_reg[LDCC_B_GATE_RGB]) &&
               !pin_filt[0])
      begin
         rgb_out <= '0;
      end
      else
      begin
         rgb_out <= rgb_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control-channel watchdog: prescaler of one step, then step count
   logic [31:0] presc_reg;
   logic [6:0]  step_reg;
   logic        wd_on;
   logic        fired_reg;

   assign wd_on = ctrl_txn_busy_in & ~watchdog_reg[LDCC_B_WD_OFF];

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         presc_reg          <= 32'h0000_0000;
         step_reg           <= 7'h00;
         fired_reg          <= 1'b0;
         ctrl_txn_abort_out <= 1'b0;
      end
      else if (!wd_on)
      begin
         presc_reg          <= 32'h0000_0000;
         step_reg           <= 7'h00;
         fired_reg          <= 1'b0;
         ctrl_txn_abort_out <= 1'b0;
      end
      else
      begin
         ctrl_txn_abort_out <= 1'b0;
         // zero timeout aborts at once; software must avoid it
         if (!fired_reg &&
             step_reg >= watchdog_reg[LDCC_B_WD_TIME_HI:LDCC_B_WD_TIME_LO])
         begin
            fired_reg          <= 1'b1;
            ctrl_txn_abort_out <= 1'b1;
         end
         // step count saturates so a stuck busy cannot wrap and re-fire
         if (presc_reg >= WD_STEP_CYCLES - 1)
         begin
            presc_reg <= 32'h0000_0000;
            if (step_reg != 7'h7f)
            begin
               step_reg <= step_reg + 7'h01;
            end
         end
         else
         begin
            presc_reg <= presc_reg + 32'h0000_0001;
         end
      end
   end

endmodule

// [ldcc_pkg.sv]
// constants for the control-channel configuration register bank
// assumes a 10 MHz system clock shared with the register port
package ldcc_pkg;
   // register offsets
   localparam logic [7:0] LDCC_OFS_GEN_CFG1   = 8'h03;
   localparam logic [7:0] LDCC_OFS_WATCHDOG   = 8'h04;
   localparam logic [7:0] LDCC_OFS_SBUS_CTRL1 = 8'h05;
   localparam logic [7:0] LDCC_OFS_SBUS_CTRL2 = 8'h06;
   // reset values
   localparam logic [7:0] LDCC_RST_GEN_CFG1   = 8'hf0;
   localparam logic [7:0] LDCC_RST_WATCHDOG   = 8'hfe;
   localparam logic [7:0] LDCC_RST_SBUS_CTRL1 = 8'h1e;
   localparam logic [7:0] LDCC_RST_SBUS_CTRL2 = 8'h00;
   // general config one fields
   localparam int LDCC_B_RSVD7     = 7;
   localparam int LDCC_B_CRC_GEN   = 6;
   localparam int LDCC_B_PULL_DOWN = 5;
   localparam int LDCC_B_FILTER    = 4;
   localparam int LDCC_B_PASS_DEC  = 3;
   localparam int LDCC_B_AUTO_ACK  = 2;
   localparam int LDCC_B_GATE_RGB  = 1;
   // writable mask of general config one, bit 0 is read only
   localparam logic [7:0] LDCC_GEN_CFG1_WMASK = 8'hfe;
   // watchdog fields
   localparam int LDCC_B_WD_TIME_HI = 7;
   localparam int LDCC_B_WD_TIME_LO = 1;
   localparam int LDCC_B_WD_OFF     = 0;
   // serial bus control one fields
   localparam int LDCC_B_PASS_ALL  = 7;
   localparam int LDCC_B_HOLD_HI   = 6;
   localparam int LDCC_B_HOLD_LO   = 4;
   localparam int LDCC_B_DEPTH_HI  = 3;
   localparam int LDCC_B_DEPTH_LO  = 0;
   // timing
   localparam int LDCC_CLK_PERIOD_NS  = 100;
   localparam int LDCC_WD_STEP_NS     = 2_000_000;
   localparam int LDCC_WD_STEP_CYCLES = LDCC_WD_STEP_NS / LDCC_CLK_PERIOD_NS;
   localparam int LDCC_FILT_SINGLE    = 2;
   localparam int LDCC_FILT_DUAL      = 4;
   localparam int LDCC_SYNC_STAGES    = 3;
   localparam int LDCC_RGB_W          = 24;
endpackage

// [ldcc_config_bank_asserts.sv]
// port assertions for the config bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module ldcc_config_bank_asserts
   import ldcc_pkg::*;
(
   input wire logic                  sys_clk_in,
   input wire logic                  sys_rst_in,
   input wire logic [7:0]            reg_addr_in,
   input wire logic [7:0]            reg_wdata_in,
   input wire logic                  reg_wr_in,
   input wire logic                  reg_rd_in,
   input wire logic [7:0]            reg_rdata_out,
   input wire logic                  reg_rvalid_out,
   input wire logic                  protected_pair_in,
   input wire logic [LDCC_RGB_W-1:0] rgb_in,
   input wire logic [LDCC_RGB_W-1:0] rgb_out,
   input wire logic                  data_enable_out,
   input wire logic                  backchan_on_in,
   input wire logic                  backchan_crc_gen_on_out,
   input wire logic                  pass_decode_out,
   input wire logic                  pass_all_out,
   input wire logic                  backchan_active_out,
   input wire logic [2:0]            sda_hold_out,
   input wire logic [3:0]            glitch_depth_out,
   input wire logic                  ctrl_txn_busy_in,
   input wire logic                  ctrl_txn_abort_out
);
   default clocking dcb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////////////////
   chk_read_valid: assert property (
      !$past(sys_rst_in) |-> reg_rvalid_out == $past(reg_rd_in))
      else $error("read valid pulse does not follow the read strobe");
   chk_rdata_hold: assert property (
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   chk_cfg_write: assert property (
      reg_wr_in && reg_addr_in == LDCC_OFS_GEN_CFG1 |=> ##1
      backchan_crc_gen_on_out == $past(reg_wdata_in[6], 2) &&
      pass_decode_out == $past(reg_wdata_in[3], 2))
      else $error("general config field not copied to its output");
   chk_sbus_write: assert property (
      reg_wr_in && reg_addr_in == LDCC_OFS_SBUS_CTRL1 |=> ##1
      {pass_all_out, sda_hold_out, glitch_depth_out} == $past(reg_wdata_in, 2))
      else $error("bus control fields not copied to outputs");
   // pass bits seen through their output copies, same lag as the or term
   chk_backchan_or: assert property (
      !$past(sys_rst_in) |-> backchan_active_out ==
      ($past(backchan_on_in) | pass_decode_out | pass_all_out))
      else $error("back channel active level wrong");
   chk_rgb_pass: assert property (
      rgb_out != '0 |-> rgb_out == $past(rgb_in))
      else $error("pixel data not a one cycle copy");
   chk_rgb_gate: assert property (
      $past(protected_pair_in) && !data_enable_out && !$past(data_enable_out)
      |-> rgb_out == '0)
      else $error("pixel data not gated in protected pairing");
   chk_abort_pulse: assert property (
      ctrl_txn_abort_out |-> $past(ctrl_txn_busy_in) ##1 !ctrl_txn_abort_out)
      else $error("abort pulse without busy or longer than a cycle");
endmodule
bind ldcc_config_bank ldcc_config_bank_asserts chk_u (.sys_clk_in, .sys_rst_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
   .reg_rvalid_out, .protected_pair_in, .rgb_in, .rgb_out, .data_enable_out,
   .backchan_on_in, .backchan_crc_gen_on_out, .pass_decode_out, .pass_all_out,
   .backchan_active_out, .sda_hold_out, .glitch_depth_out, .ctrl_txn_busy_in,
   .ctrl_txn_abort_out);

// [ldcc_config_bank_tb.sv]
// self-checking bench for the config bank
// assumes ldcc_pkg, the bank and its checker are compiled first
`timescale 1ns/1ns
module ldcc_config_bank_tb;
   import ldcc_pkg::*;
   localparam int STEP = 4;
   logic        sys_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic [7:0]  reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, a;
   logic        dual_lane_in = 0, protected_pair_in = 0, reg_rvalid_out, seen;
   logic        backchan_on_in = 1, ctrl_txn_busy_in = 0, ctrl_txn_abort_out;
   logic        backchan_crc_gen_on_out, undriven_pull_down_sel_out, pass_all_out;
   logic        pass_decode_out, auto_ack_out, backchan_active_out;
   logic [2:0]  pins = 0, pout, sda_hold_out;
   logic [3:0]  glitch_depth_out;
   logic [23:0] rgb_in = 0, rgb_out;
   logic [7:0]  mdl [0:7] = '{3: 8'hf0, 4: 8'hfe, 5: 8'h1e, default: 8'h00};
   int          error_cnt = 0, checks_done = 0, seed = 3, cyc = 0, first, cnt;
   ldcc_config_bank #(.WD_STEP_CYCLES(STEP)) dut_u (.sys_clk_in, .sys_rst_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
      .reg_rvalid_out, .data_enable_in(pins[0]), .horizontal_sync_in(pins[1]),
      .vertical_sync_in(pins[2]), .dual_lane_in, .protected_pair_in, .rgb_in,
      .backchan_on_in, .ctrl_txn_busy_in, .data_enable_out(pout[0]),
      .horizontal_sync_out(pout[1]), .vertical_sync_out(pout[2]), .rgb_out,
      .backchan_crc_gen_on_out, .undriven_pull_down_sel_out, .pass_decode_out,
      .pass_all_out, .auto_ack_out, .backchan_active_out, .sda_hold_out,
      .glitch_depth_out, .ctrl_txn_abort_out);
   ////////////////////////////////////////////////////////////////////////
   always #50 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in)
   begin
      rgb_in <= 24'($random(seed));
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt++;
         wrap_up();
      end
   end
   task wrap_up;
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [23:0] exp, got);
      if (exp !== got)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
      checks_done++;
   endtask
   // unmapped and 0x06 take no bits, 0x03 bit 0 stays read only
   function logic [7:0] wmask(input logic [7:0] ad);
      return ad == 3 ? 8'hfe : ((ad == 4 || ad == 5) ? 8'hff : 8'h00);
   endfunction
   task wr(input logic [7:0] ad, d);
      @(posedge sys_clk_in);
      {reg_addr_in, reg_wdata_in, reg_wr_in} <= {ad, d, 1'b1};
      @(posedge sys_clk_in);
      reg_wr_in <= 0;
      if (wmask(ad) != 0)
         mdl[ad[2:0]] = d & wmask(ad);
   endtask
   task rd(input logic [7:0] ad);
      @(posedge sys_clk_in);
      {reg_addr_in, reg_rd_in} <= {ad, 1'b1};
      @(posedge sys_clk_in);
      reg_rd_in <= 0;
      #1;
      chk("rvalid", 1, reg_rvalid_out);
      chk("rdata", mdl[ad[2:0]], reg_rdata_out);
   endtask
   // a pulse held over w edges, then the output watched for a while
   task pulse(input int sel, w, input logic exp);
      seen = 0;
      @(posedge sys_clk_in);
      pins[sel] <= 1;
      repeat (w) @(posedge sys_clk_in);
      pins[sel] <= 0;
      repeat (16) @(posedge sys_clk_in) #1 seen |= pout[sel];
      chk("sync_seen", exp, seen);
      chk("sync_idle", 0, pout[sel]);
   endtask
   task wd(input int len);
      {first, cnt} = 0;
      @(posedge sys_clk_in);
      ctrl_txn_busy_in <= 1;
      for (int k = 1; k <= len; k++)
      begin
         @(posedge sys_clk_in);
         #1;
         if (ctrl_txn_abort_out === 1'b1)
            {first, cnt} = {k, cnt + 1};
      end
      ctrl_txn_busy_in <= 0;
      repeat (3) @(posedge sys_clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge sys_clk_in);
      sys_rst_in <= 0;
      @(posedge sys_clk_in);
      #1;
      chk("flags", 6'h31, {backchan_crc_gen_on_out, undriven_pull_down_sel_out,
         pass_decode_out, auto_ack_out, pass_all_out, backchan_active_out});
      chk("bus_fields", 7'h1e, {sda_hold_out, glitch_depth_out});
      for (int i = 3; i < 7; i++) rd(8'(i));
      for (int i = 0; i < 40; i++)
      begin
         a = 8'(2 + {$random(seed)} % 6);
         {backchan_on_in, protected_pair_in} <= 2'($random(seed));
         wr(a, 8'($random(seed)));
         rd(a);
      end
      chk("cfg_out", {mdl[3][6:5], mdl[3][3:2]}, {backchan_crc_gen_on_out,
         undriven_pull_down_sel_out, pass_decode_out, auto_ack_out});
      chk("sbus_out", mdl[5], {pass_all_out, sda_hold_out, glitch_depth_out});
      backchan_on_in <= 0;
      wr(3, 8'h00);
      wr(5, 8'h00);
      @(posedge sys_clk_in);
      #1 chk("bc_off", 0, backchan_active_out);
      wr(5, 8'h80);
      @(posedge sys_clk_in);
      #1 chk("bc_keep", 1, backchan_active_out);
      wr(6, 8'hff);
      rd(6);
      wr(3, 8'hff);
      rd(3);
      protected_pair_in <= 0;
      wr(3, 8'hf2);
      repeat (2) @(posedge sys_clk_in);
      #1 chk("rgb_gate", 0, rgb_out);
      wr(3, 8'hf0);
      repeat (2) @(posedge sys_clk_in);
      #1 chk("rgb_pass", 1, rgb_out != 0);
      protected_pair_in <= 1;
      repeat (2) @(posedge sys_clk_in);
      #1 chk("rgb_prot", 0, rgb_out);
      protected_pair_in <= 0;
      pulse(0, 1, 0);
      pulse(2, 1, 0);
      pulse(0, 10, 1);
      pulse(1, 3, 1);
      dual_lane_in <= 1;
      pulse(1, 3, 0);
      pulse(1, 6, 1);
      dual_lane_in <= 0;
      wr(3, 8'he0);
      pulse(2, 2, 1);
      wr(4, 8'h06);
      wd(30);
      chk("wd_time", 1, first >= 3 * STEP - 2 && first <= 3 * STEP + 4);
      chk("wd_once", 1, cnt);
      wd(8);
      chk("wd_early", 0, cnt);
      wr(4, 8'h07);
      wd(30);
      chk("wd_off", 0, cnt);
      wrap_up();
   end
endmodule
